// ==== inc/font_regs_pkg.sv ====
`default_nettype none
package font_regs_pkg;
    localparam int unsigned NUM_REGS = 10;
    localparam logic [3:0]  SLOT_COUNT = 4'hA;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINE_SPACING = 8'h29;
    localparam logic [7:0] IDX_CURSOR_X_LOW = 8'h2A;
    localparam logic [7:0] IDX_CURSOR_X_HIGH = 8'h2B;
    localparam logic [7:0] IDX_CURSOR_Y_LOW = 8'h2C;
    localparam logic [7:0] IDX_CURSOR_Y_HIGH = 8'h2D;
    localparam logic [7:0] IDX_GLYPH_SIZE = 8'h2E;
    localparam logic [7:0] IDX_FONT_ROM = 8'h2F;
    localparam logic [7:0] IDX_WIN_X_LOW = 8'h30;
    localparam logic [7:0] IDX_WIN_X_HIGH = 8'h31;
    localparam logic [7:0] IDX_WIN_Y_LOW = 8'h32;
    localparam logic [7:0] FIRST_IDX = IDX_LINE_SPACING;
    localparam logic [7:0] LAST_IDX = IDX_WIN_Y_LOW;

    // Bank slots, index minus FIRST_IDX
    localparam logic [3:0] SLOT_SPACING = 4'h0;
    localparam logic [3:0] SLOT_X_LOW = 4'h1;
    localparam logic [3:0] SLOT_X_HIGH = 4'h2;
    localparam logic [3:0] SLOT_Y_LOW = 4'h3;
    localparam logic [3:0] SLOT_Y_HIGH = 4'h4;
    localparam logic [3:0] SLOT_GLYPH = 4'h5;
    localparam logic [3:0] SLOT_ROM = 4'h6;
    localparam logic [3:0] SLOT_WX_LOW = 4'h7;
    localparam logic [3:0] SLOT_WX_HIGH = 4'h8;
    localparam logic [3:0] SLOT_WY_LOW = 4'h9;

    // Implemented bits per slot, and which slots the cursor reload hits
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'h1F, 8'hFF, 8'h03,
        8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF};
    localparam logic [NUM_REGS-1:0] CURSOR_SLOTS = 10'h01E;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Field positions
    localparam int unsigned SIZE_LSB = 6;
    localparam int unsigned ROMTYPE_LSB = 5;
    localparam int unsigned ENC_LSB = 2;

    // Glyph heights in pixels
    localparam logic [5:0] HEIGHT_16 = 6'h10;
    localparam logic [5:0] HEIGHT_24 = 6'h18;
    localparam logic [5:0] HEIGHT_32 = 6'h20;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {ENC_GB2312, ENC_GB12345, ENC_BIG5,
        ENC_UNICODE, ENC_ASCII, ENC_UNI_JAPANESE, ENC_JIS,
        ENC_RESERVED} encoding_t;
    typedef enum {RD_IDLE, RD_FETCH, RD_LOAD, RD_RESP} rd_state_t;
endpackage
`default_nettype wire

// ==== inc/reg_store_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface reg_store_if;
    import font_regs_pkg::*;
    logic       wrEn;
    logic [3:0] wrSlot;
    logic [7:0] wrData;
    logic       curLoad;
    logic [9:0] curX;
    logic [8:0] curY;
    logic [3:0] rdSlot;
    logic [7:0] rdData;
    logic [7:0] image [NUM_REGS];
    modport bank (input wrEn, wrSlot, wrData, curLoad, curX, curY,
                  rdSlot, output rdData, image);
    modport ctrl (output wrEn, wrSlot, wrData, curLoad, curX, curY,
                  rdSlot, input rdData, image);
endinterface
`default_nettype wire

// ==== rtl/reg_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_store
    import font_regs_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    reg_store_if.bank st
);
    logic [7:0] curByte [NUM_REGS];

    // Cursor bytes offered for a hardware reload
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            curByte[i] = RESET_BYTE;
        end
        curByte[SLOT_X_LOW] = st.curX[7:0];
        curByte[SLOT_X_HIGH] = {6'h00, st.curX[9:8]};
        curByte[SLOT_Y_LOW] = st.curY[7:0];
        curByte[SLOT_Y_HIGH] = {7'h00, st.curY[8]};
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gen_entry
            // Software write beats a cursor reload on the same entry
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    st.image[g] <= RESET_BYTE;
                end else if (ce) begin
                    if (st.wrEn && st.wrSlot == 4'(g)) begin
                        st.image[g] <= st.wrData & REG_MASK[g];
                    end else if (st.curLoad && CURSOR_SLOTS[g]) begin
                        st.image[g] <= curByte[g] & REG_MASK[g];
                    end
                end
            end

            chk_unused_zero: assert property (
                @(posedge core_clk) disable iff (rst)
                (st.image[g] & ~REG_MASK[g]) == 8'h00)
                else $error("unused register bits not zero");
        end
    endgenerate

    // Registered read port; slots past the bank read as zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st.rdData <= RESET_BYTE;
        end else if (ce) begin
            if (st.rdSlot < SLOT_COUNT) begin
                st.rdData <= st.image[st.rdSlot];
            end else begin
                st.rdData <= RESET_BYTE;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/font_write_and_window_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module font_write_and_window_regs
    import font_regs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        cursorNewLine,
    input  wire logic        windowYStartBit8,
    output logic [4:0]       lineSpacing,
    output logic [9:0]       cursorX,
    output logic [8:0]       cursorY,
    output logic [1:0]       glyphSize,
    output logic [5:0]       glyphHeight,
    output logic [5:0]       charGap,
    output logic [2:0]       fontRomType,
    output logic [2:0]       fontEncoding,
    output logic [1:0]       glyphStyle,
    output logic [9:0]       windowXStart,
    output logic [8:0]       windowYStart
);
    logic       awHeld;
    logic [7:0] awAddrQ;
    logic       wHeld;
    logic [7:0] wDataQ;
    logic       wLaneQ;
    logic       doWrite;
    rd_state_t  rdState;
    logic [3:0] rdSlotQ;
    logic       rdHitQ;
    logic [8:0] next_cursorY;
    logic [7:0] lastWrData;

    reg_store_if st();

    // Word index of a byte address; the low two bits do not matter
    function automatic logic [7:0] wordIdx(input logic [7:0] a);
        wordIdx = {2'h0, a[7:2]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (wordIdx(a) >= FIRST_IDX) && (wordIdx(a) <= LAST_IDX);
    endfunction

    function automatic logic [3:0] slotOf(input logic [7:0] a);
        logic [7:0] d;
        d = wordIdx(a) - FIRST_IDX;
        slotOf = d[3:0];
    endfunction

    // Size code 1X means 32 pixels whatever the low bit says
    function automatic logic [5:0] heightOf(input logic [1:0] code);
        if (code[1]) begin
            heightOf = HEIGHT_32;
        end else if (code[0]) begin
            heightOf = HEIGHT_24;
        end else begin
            heightOf = HEIGHT_16;
        end
    endfunction

    reg_store u_store (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .st       (st)
    );

    // New line: back to the window's left edge, down one text row
    assign next_cursorY = cursorY + {3'h0, glyphHeight}
                        + {4'h0, lineSpacing};
    assign st.curLoad = cursorNewLine;
    assign st.curX = windowXStart;
    assign st.curY = next_cursorY;

    // Only byte lane 0 carries a register; other lanes are dropped
    assign doWrite = awHeld && wHeld && !bvalid;
    assign st.wrEn = doWrite && mapped(awAddrQ) && wLaneQ;
    assign st.wrSlot = slotOf(awAddrQ);
    assign st.wrData = wDataQ;
    assign st.rdSlot = rdSlotQ;

    // Write address: held until paired with its data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            awready <= 1'b0;
            awAddrQ <= 8'h00;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awready <= 1'b0;
                awAddrQ <= awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end else if (!awHeld && !bvalid) begin
                awready <= 1'b1;
            end
        end
    end

    // Write data: either order against the address is fine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wHeld <= 1'b0;
            wready <= 1'b0;
            wDataQ <= 8'h00;
            wLaneQ <= 1'b0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wready <= 1'b0;
                wDataQ <= wdata[7:0];
                wLaneQ <= wstrb[0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end else if (!wHeld && !bvalid) begin
                wready <= 1'b1;
            end
        end
    end

    // Write response; an unmapped address stores nothing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= mapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read: capture, bank lookup, then present; the extra stage
    // keeps rdata a flop that stands still while rvalid waits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdState <= RD_IDLE;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            rdSlotQ <= 4'h0;
            rdHitQ <= 1'b0;
        end else if (ce) begin
            case (rdState)
                RD_IDLE: begin
                    arready <= 1'b1;
                    if (arvalid && arready) begin
                        arready <= 1'b0;
                        rdSlotQ <= slotOf(araddr);
                        rdHitQ <= mapped(araddr);
                        rdState <= RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    rdState <= RD_LOAD;
                end
                RD_LOAD: begin
                    rvalid <= 1'b1;
                    if (rdHitQ) begin
                        rdata <= {24'h00_0000, st.rdData};
                        rresp <= RESP_OKAY;
                    end else begin
                        rdata <= 32'h0000_0000;
                        rresp <= RESP_SLVERR;
                    end
                    rdState <= RD_RESP;
                end
                RD_RESP: begin
                    if (rvalid && rready) begin
                        rvalid <= 1'b0;
                        rdState <= RD_IDLE;
                    end
                end
                default: begin
                    rdState <= RD_IDLE;
                end
            endcase
        end
    end

    // Field outputs, one cycle behind the bank
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lineSpacing <= '0;
            cursorX <= '0;
            cursorY <= '0;
            glyphSize <= '0;
            glyphHeight <= HEIGHT_16;
            charGap <= '0;
            fontRomType <= '0;
            fontEncoding <= '0;
            glyphStyle <= '0;
            windowXStart <= '0;
            windowYStart <= '0;
        end else if (ce) begin
            lineSpacing <= st.image[SLOT_SPACING][4:0];
            cursorX <= {st.image[SLOT_X_HIGH][1:0],
                        st.image[SLOT_X_LOW]};
            cursorY <= {st.image[SLOT_Y_HIGH][0],
                        st.image[SLOT_Y_LOW]};
            glyphSize <= st.image[SLOT_GLYPH][SIZE_LSB +: 2];
            glyphHeight <= heightOf(
                st.image[SLOT_GLYPH][SIZE_LSB +: 2]);
            charGap <= st.image[SLOT_GLYPH][5:0];
            fontRomType <= st.image[SLOT_ROM][ROMTYPE_LSB +: 3];
            fontEncoding <= st.image[SLOT_ROM][ENC_LSB +: 3];
            glyphStyle <= st.image[SLOT_ROM][1:0];
            windowXStart <= {st.image[SLOT_WX_HIGH][1:0],
                             st.image[SLOT_WX_LOW]};
            windowYStart <= {windowYStartBit8,
                             st.image[SLOT_WY_LOW]};
        end
    end

    // Helper for the checks: last byte handed to the bank
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lastWrData <= RESET_BYTE;
        end else if (ce && st.wrEn) begin
            lastWrData <= st.wrData;
        end
    end

    // Checks; a frozen cycle abandons any attempt in flight
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !ce);

    chk_spacing_write: assert property (
        st.wrEn && st.wrSlot == SLOT_SPACING |->
        ##2 lineSpacing == lastWrData[4:0])
        else $error("line spacing not taken from write");

    chk_newline_step: assert property (
        st.curLoad && !st.wrEn |->
        ##2 cursorY == $past(next_cursorY, 2)
        && cursorX == $past(windowXStart, 2))
        else $error("new line did not move the cursor");

    chk_cursor_x_high: assert property (
        st.wrEn && st.wrSlot == SLOT_X_HIGH && !st.curLoad |->
        ##2 cursorX[9:8] == lastWrData[1:0])
        else $error("cursor X bits 9:8 wrong");

    chk_cursor_y_high: assert property (
        st.wrEn && st.wrSlot == SLOT_Y_HIGH && !st.curLoad |->
        ##2 cursorY[8] == lastWrData[0])
        else $error("cursor Y bit 8 wrong");

    chk_glyph_height: assert property (
        (glyphSize[1] |-> glyphHeight == HEIGHT_32)
        and (glyphSize == 2'h1 |-> glyphHeight == HEIGHT_24)
        and (glyphSize == 2'h0 |-> glyphHeight == HEIGHT_16))
        else $error("glyph height does not match size code");

    chk_gap_and_size: assert property (
        st.wrEn && st.wrSlot == SLOT_GLYPH |->
        ##2 charGap == lastWrData[5:0]
        && glyphSize == lastWrData[7:6])
        else $error("gap or size field wrong");

    chk_rom_fields: assert property (
        st.wrEn && st.wrSlot == SLOT_ROM |->
        ##2 fontEncoding == lastWrData[4:2]
        && glyphStyle == lastWrData[1:0])
        else $error("encoding or style field wrong");

    chk_rom_type: assert property (
        st.wrEn && st.wrSlot == SLOT_ROM |->
        ##2 fontRomType == lastWrData[7:5])
        else $error("font ROM type field wrong");

    chk_window_x: assert property (
        st.wrEn && st.wrSlot == SLOT_WX_HIGH |->
        ##2 windowXStart[9:8] == lastWrData[1:0])
        else $error("window X start bits 9:8 wrong");

    chk_window_y_low: assert property (
        st.wrEn && st.wrSlot == SLOT_WY_LOW |->
        ##2 windowYStart[7:0] == lastWrData)
        else $error("window Y start low byte wrong");

    chk_window_y_bit8: assert property (
        $rose(windowYStartBit8) |-> ##1 windowYStart[8])
        else $error("window Y start bit 8 not followed");

    chk_read_zero_pad: assert property (
        rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    chk_read_latency: assert property (
        arvalid && arready |-> ##1 !rvalid [*2] ##1 rvalid)
        else $error("read answer not on third edge");

    chk_unmapped_read: assert property (
        arvalid && arready && !mapped(araddr) |->
        ##3 rresp == RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    chk_write_resp: assert property (
        doWrite |=> bvalid && !awready && !wready)
        else $error("write response missing");

    cov_glyph_write: cover property (
        st.wrEn && st.wrSlot == SLOT_GLYPH);
    cov_read_done: cover property (rvalid && rready && rresp == RESP_OKAY);
    cov_new_line: cover property (st.curLoad ##2 cursorY != 9'h000);
    cov_bad_write: cover property (bvalid && bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ==== verification/font_write_and_window_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module font_write_and_window_regs_bench
    import font_regs_pkg::*;
;
    localparam int LIMIT = 5000;
    // Mapped words: address, value written, value read back
    localparam logic [7:0] ADDR [10] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0,
        8'hB4, 8'hB8, 8'hBC, 8'hC0, 8'hC4, 8'hC8};
    localparam logic [7:0] WVAL [10] = '{8'hFF, 8'h5A, 8'hFF, 8'hA5,
        8'hFF, 8'h7B, 8'hB6, 8'h3C, 8'hFE, 8'h99};
    localparam logic [7:0] EXPRD [10] = '{8'h1F, 8'h5A, 8'h03, 8'hA5,
        8'h01, 8'h7B, 8'hB6, 8'h3C, 8'h02, 8'h99};

    logic        core_clk;
    logic        rst;
    logic        ce;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        cursorNewLine;
    logic        windowYStartBit8;
    logic [4:0]  lineSpacing;
    logic [9:0]  cursorX;
    logic [8:0]  cursorY;
    logic [1:0]  glyphSize;
    logic [5:0]  glyphHeight;
    logic [5:0]  charGap;
    logic [2:0]  fontRomType;
    logic [2:0]  fontEncoding;
    logic [1:0]  glyphStyle;
    logic [9:0]  windowXStart;
    logic [8:0]  windowYStart;
    logic [1:0]  resp;
    int          failCount;
    int          checks;
    int          cycles = 0;

    font_write_and_window_regs font_write_and_window_regs_i (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cursorNewLine(cursorNewLine),
        .windowYStartBit8(windowYStartBit8),
        .lineSpacing(lineSpacing), .cursorX(cursorX), .cursorY(cursorY),
        .glyphSize(glyphSize), .glyphHeight(glyphHeight),
        .charGap(charGap), .fontRomType(fontRomType),
        .fontEncoding(fontEncoding), .glyphStyle(glyphStyle),
        .windowXStart(windowXStart), .windowYStart(windowYStart)
    );

    // Free running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Ready looked at on the falling edge, so the rising edge cannot race
    task automatic axWrite(input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] s, output logic [1:0] r);
        logic awHit;
        logic wHit;
        logic bHit;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bHit = 1'b0;
        while (!bHit) begin
            @(negedge core_clk);
            awHit = awvalid & awready;
            wHit = wvalid & wready;
            bHit = bvalid & bready;
            r = bresp;
            @(posedge core_clk);
            if (awHit) awvalid <= 1'b0;
            if (wHit) wvalid <= 1'b0;
            if (bHit) bready <= 1'b0;
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] expD,
                         input logic [1:0] expR);
        logic arHit;
        logic rHit;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rHit = 1'b0;
        while (!rHit) begin
            @(negedge core_clk);
            arHit = arvalid & arready;
            rHit = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (arHit) arvalid <= 1'b0;
            if (rHit) rready <= 1'b0;
        end
        chk(d, expD);
        chk(r, expR);
    endtask

    // Every field output at its cleared value
    task automatic rstChk();
        chk({lineSpacing, cursorX, cursorY, glyphSize}, 0);
        chk({glyphHeight, charGap, fontRomType, fontEncoding, glyphStyle},
            {HEIGHT_16, 14'h0000});
        chk({windowXStart, windowYStart}, 0);
    endtask

    // Hang guard; a run of a few hundred cycles is expected
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failCount++;
            give_verdict();
        end
    end

    initial begin
        {rst, ce, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, cursorNewLine, windowYStartBit8} = '0;
        {failCount, checks} = '0;
        rst = 1'b1;
        ce = 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rstChk();
        @(posedge core_clk);
        rst <= 1'b0;
        // Reset contents, then write and read back each word
        for (int i = 0; i < 10; i++) begin
            rdChk(ADDR[i], 0, RESP_OKAY);
        end
        for (int i = 0; i < 10; i++) begin
            axWrite(ADDR[i], WVAL[i], 4'h1, resp);
            chk(resp, RESP_OKAY);
            rdChk(ADDR[i], EXPRD[i], RESP_OKAY);
        end
        @(negedge core_clk);
        chk({lineSpacing, cursorX, cursorY, glyphSize},
            {5'h1F, 10'h35A, 9'h1A5, 2'h1});
        chk({glyphHeight, charGap, fontRomType, fontEncoding, glyphStyle},
            {HEIGHT_24, 6'h3B, 3'h5, 3'h5, 2'h2});
        chk({windowXStart, windowYStart}, {10'h23C, 9'h099});
        // Every size code; gap zero means no spacing
        for (int i = 0; i < 4; i++) begin
            axWrite(8'hB8, {i[1:0], 6'h00}, 4'h1, resp);
            @(negedge core_clk);
            chk({glyphSize, glyphHeight, charGap}, {i[1:0], (i == 0) ?
                HEIGHT_16 : (i == 1) ? HEIGHT_24 : HEIGHT_32,
                6'h00});
        end
        // Every ROM type, encoding and style code
        for (int i = 0; i < 8; i++) begin
            axWrite(8'hBC, {i[2:0], i[2:0], i[1:0]}, 4'h1, resp);
            @(negedge core_clk);
            chk({fontRomType, fontEncoding, glyphStyle},
                {i[2:0], i[2:0], i[1:0]});
        end
        // Lane 0 disabled: answered but nothing stored
        axWrite(8'hA4, 8'h05, 4'h0, resp);
        chk(resp, RESP_OKAY);
        rdChk(8'hA4, 32'h0000_001F, RESP_OKAY);
        // Holes on both sides of the bank
        axWrite(8'h00, 8'h12, 4'h1, resp);
        chk(resp, RESP_SLVERR);
        axWrite(8'hCC, 8'h34, 4'h1, resp);
        chk(resp, RESP_SLVERR);
        rdChk(8'h00, 0, RESP_SLVERR);
        rdChk(8'hCC, 0, RESP_SLVERR);
        // New line from Y 0x1F0 wraps past the 9-bit top
        axWrite(8'hB0, 8'hF0, 4'h1, resp);
        @(posedge core_clk);
        cursorNewLine <= 1'b1;
        @(posedge core_clk);
        cursorNewLine <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk(cursorY, 9'(9'h1F0 + HEIGHT_32 + 5'h1F));
        chk(cursorX, 10'h23C);
        rdChk(8'hB0, 32'h0000_002F, RESP_OKAY);
        rdChk(8'hB4, 0, RESP_OKAY);
        rdChk(8'hA8, 32'h0000_003C, RESP_OKAY);
        rdChk(8'hAC, 32'h0000_0002, RESP_OKAY);
        // Top bit of window Y comes from the neighbour
        @(posedge core_clk);
        windowYStartBit8 <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk(windowYStart, 9'h199);
        // Clock enable low: a new line request in that cycle is lost
        @(posedge core_clk);
        ce <= 1'b0;
        cursorNewLine <= 1'b1;
        @(posedge core_clk);
        ce <= 1'b1;
        cursorNewLine <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk(cursorY, 9'h02F);
        // Software side: size bits cleared before an external ROM
        axWrite(8'hB8, 8'h05, 4'h1, resp);
        axWrite(8'hBC, 8'hE4, 4'h1, resp);
        @(negedge core_clk);
        chk({glyphSize, glyphHeight, charGap, fontRomType},
            {2'h0, HEIGHT_16, 6'h05, 3'h7});
        // Back to the internal ROM: whole settings register cleared
        axWrite(8'hBC, 8'h00, 4'h1, resp);
        @(negedge core_clk);
        chk({fontRomType, fontEncoding, glyphStyle}, 8'h00);
        // Second reset in mid-run clears everything
        @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        rstChk();
        @(posedge core_clk);
        rst <= 1'b0;
        rdChk(8'hC8, 0, RESP_OKAY);
        rdChk(8'hBC, 0, RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
